// >>> rtl/brsi_pkg.sv
// Register map, bit positions and state layout of the receive status block
package brsi_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_SUMMARY = 8'h30;
  localparam logic [7:0] IDX_LIVE = 8'h31;
  localparam logic [7:0] IDX_ALARM = 8'h33;
  localparam logic [7:0] IDX_IER1 = 8'h34;
  localparam logic [7:0] IDX_DS1SR = 8'h35;
  localparam logic [7:0] IDX_E1SR = 8'h36;
  localparam logic [7:0] IDX_IER3 = 8'h37;
  localparam logic [7:0] IDX_MODE = 8'h3f;
  // Alarm latch and live condition bits; clear events sit four bits up
  localparam int ALM_OOF = 0;
  localparam int ALM_LOS = 1;
  localparam int ALM_AIS = 2;
  localparam int ALM_RAI = 3;
  localparam int ALM_CLR_BASE = 4;
  // DS1 event latch bits
  localparam int DS1_FRAME_BIT_ERR = 0;
  localparam int DS1_B8ZS = 1;
  localparam int DS1_SEVERE_FRAMING = 2;
  localparam int DS1_Z16 = 3;
  localparam int DS1_Z8 = 4;
  localparam int DS1_ALIGN_CHANGE = 5;
  localparam int DS1_PDV = 7;
  // E1 event latch bits; only the low four can interrupt
  localparam int E1_ALIGN_TICK = 0;
  localparam int E1_MF_TICK = 1;
  localparam int E1_SA0 = 2;
  localparam int E1_SA1 = 3;
  localparam int E1_FAS_RESYNC = 4;
  localparam int E1_CAS_RESYNC = 5;
  localparam int E1_CRC_RESYNC = 6;
  localparam int E1_IRQ_BITS = 4;
  // Summary and mode bits
  localparam int SUM_SR1 = 0;
  localparam int SUM_SR3 = 1;
  localparam int MODE_E1 = 0;
  // Reset values and zero-run thresholds
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [4:0] RST_ZRUN = 5'h00;
  localparam logic [4:0] ZERO_RUN_SHORT = 5'h08;
  localparam logic [4:0] ZERO_RUN_LONG = 5'h10;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic [7:0] ier1;
    logic [3:0] ier3;
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
    logic mode;
    logic [3:0] live_prev;
    logic [2:0] crit_prev;
    logic [4:0] zrun;
  } brsi_state_type;
endpackage : brsi_pkg

// >>> rtl/brsi_top.sv
// Receive status latches, interrupt enables and request for the BITS framer
// Overview of operation
// - Signal-loss latch sets on live rise; write-one clears; maskable.
// - Out-of-frame latch sets on live rise; write-one clears; maskable.
// - First enable register holds eight enables, one per alarm latch bit.
// - DS1 event register is DS1 only and never requests an interrupt.
// - Density violation sets on sixteen zeros or a window failure.
// - Alignment-change latch sets when a resync moved the alignment.
// - Eight-zero latch sets once eight consecutive zeros arrive.
// - Sixteen-zero latch sets once sixteen consecutive zeros arrive.
// - Severe framing latch sets on two of six framing bits wrong.
// - Codeword latch sets on any B8ZS codeword regardless of line coding.
// - Frame bit error latch sets on any single framing bit error.
// - E1 event register is meaningful only with E1 mode selected.
// - CRC-4 resync latch sets on a fresh criterion hit, never interrupts.
// - CAS resync latch sets on a fresh criterion hit, never interrupts.
// - FAS resync latch sets on a fresh criterion hit, never interrupts.
// - All-ones signalling latch: framer sets, write-one clears, maskable.
// - All-zeros signalling latch: framer sets, write-one clears, maskable.
// - Multiframe latch sets each CRC-4 multiframe; write-one clears.
// - Align-frame latch sets each align frame, write-one clears, maskable.
// - The four maskable E1 latches stay zero outside E1 mode.
// - Third enable register holds four enables for the low E1 latches.
// - Clear-event latches set on live condition fall, write-one clears.
// - Summary shows per alarm and E1 status register whether an unmasked latch is set.
`timescale 1ns/1ps
module brsi_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Live framer conditions
  input wire logic live_rai,
  input wire logic live_ais,
  input wire logic live_los,
  input wire logic live_oof,
  // DS1 receive data and event pulses
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic density_window_fail,
  input wire logic alignment_changed,
  input wire logic severe_framing_error,
  input wire logic b8zs_codeword,
  input wire logic frame_bit_error,
  // E1 resync criteria levels and event pulses
  input wire logic crc4_resync_hit,
  input wire logic cas_resync_hit,
  input wire logic fas_resync_hit,
  input wire logic sig_all_ones,
  input wire logic sig_all_zeros,
  input wire logic crc4_multiframe_tick,
  input wire logic align_frame_tick,
  // Mode and interrupt
  output logic rx_e1_select,
  output logic irq_out
);

  brsi_pkg::brsi_state_type st_q;
  brsi_pkg::brsi_state_type st_d;

  logic req;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [3:0] live;
  logic [2:0] crit;
  logic [2:0] crit_rise;
  logic zero_bit;
  logic z8_hit;
  logic z16_hit;
  logic ds1;
  logic sum1;
  logic sum3;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] clr3;

  // Bus strobes; ack alternates so every request gets exactly one pulse
  assign req = wb_cyc_i & wb_stb_i & ~st_q.ack;
  // Writes commit on the edge where the master samples ack high
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & st_q.ack;
  assign idx = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];
  assign ds1 = ~st_q.mode;

  // Edge detection against the previous live levels
  assign live = {live_rai, live_ais, live_los, live_oof};
  assign set1 = {~live & st_q.live_prev,
                 live & ~st_q.live_prev};

  // Zero-run counter on the DS1 bit stream
  assign zero_bit = rx_bit_valid & ~rx_bit;
  assign z8_hit = zero_bit &
                  (st_q.zrun + 5'h01 == brsi_pkg::ZERO_RUN_SHORT);
  assign z16_hit = zero_bit &
                   (st_q.zrun + 5'h01 == brsi_pkg::ZERO_RUN_LONG);

  // DS1 events only latch in DS1 mode
  assign set2 = {z16_hit | density_window_fail,
                 1'b0,
                 alignment_changed,
                 z8_hit,
                 z16_hit,
                 severe_framing_error,
                 b8zs_codeword,
                 frame_bit_error} & {8{ds1}};

  // Resync latches fire only on a fresh rise of their criterion
  assign crit = {crc4_resync_hit, cas_resync_hit, fas_resync_hit};
  assign crit_rise = crit & ~st_q.crit_prev;
  assign set3 = {1'b0,
                 crit_rise,
                 sig_all_ones,
                 sig_all_zeros,
                 crc4_multiframe_tick,
                 align_frame_tick} & {8{st_q.mode}};

  // Write-one clear masks
  assign clr1 = (wr_en && idx == brsi_pkg::IDX_ALARM) ? wbyte : 8'h00;
  assign clr2 = (wr_en && idx == brsi_pkg::IDX_DS1SR) ? wbyte : 8'h00;
  assign clr3 = (wr_en && idx == brsi_pkg::IDX_E1SR) ? wbyte : 8'h00;

  // Summary per status register; DS1 events have no part in it
  assign sum1 = |(st_q.sr1 & st_q.ier1);
  assign sum3 = |(st_q.sr3[brsi_pkg::E1_IRQ_BITS-1:0] & st_q.ier3);

  always_comb begin
    st_d = st_q;
    st_d.ack = req;
    st_d.live_prev = live;
    st_d.crit_prev = crit;
    // Set wins over a clear landing in the same cycle
    st_d.sr1 = (st_q.sr1 & ~clr1) | set1;
    st_d.sr2 = (st_q.sr2 & ~clr2) | set2;
    if (st_q.mode) begin
      st_d.sr3 = (st_q.sr3 & ~clr3) | set3;
    end else begin
      st_d.sr3 = brsi_pkg::RST_REG;
    end
    if (rx_bit_valid) begin
      if (rx_bit) begin
        st_d.zrun = brsi_pkg::RST_ZRUN;
      end else if (st_q.zrun != brsi_pkg::ZERO_RUN_LONG) begin
        // Saturate so a long string latches each event only once
        st_d.zrun = st_q.zrun + 5'h01;
      end
    end
    if (wr_en && idx == brsi_pkg::IDX_IER1) begin
      st_d.ier1 = wbyte;
    end
    // Reserved in DS1 mode, so writes there are dropped
    if (wr_en && idx == brsi_pkg::IDX_IER3 && st_q.mode) begin
      st_d.ier3 = wbyte[3:0];
    end
    if (wr_en && idx == brsi_pkg::IDX_MODE) begin
      st_d.mode = wbyte[brsi_pkg::MODE_E1];
    end
    // Read data captured with the ack; unmapped indices read zero
    st_d.rdata = 8'h00;
    if (req && !wb_we_i) begin
      unique case (idx)
        brsi_pkg::IDX_SUMMARY: st_d.rdata = {6'h00, sum3, sum1};
        brsi_pkg::IDX_LIVE: st_d.rdata = {4'h0, live};
        brsi_pkg::IDX_ALARM: st_d.rdata = st_q.sr1;
        brsi_pkg::IDX_IER1: st_d.rdata = st_q.ier1;
        brsi_pkg::IDX_DS1SR: st_d.rdata = st_q.sr2;
        brsi_pkg::IDX_E1SR: st_d.rdata = st_q.sr3;
        brsi_pkg::IDX_IER3: st_d.rdata = {4'h0, st_q.ier3};
        brsi_pkg::IDX_MODE: st_d.rdata = {7'h00, st_q.mode};
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.ack <= 1'b0;
      st_q.rdata <= brsi_pkg::RST_REG;
      st_q.ier1 <= brsi_pkg::RST_REG;
      st_q.ier3 <= brsi_pkg::RST_NIB;
      st_q.sr1 <= brsi_pkg::RST_REG;
      st_q.sr2 <= brsi_pkg::RST_REG;
      st_q.sr3 <= brsi_pkg::RST_REG;
      st_q.mode <= 1'b0;
      st_q.live_prev <= brsi_pkg::RST_NIB;
      st_q.crit_prev <= 3'h0;
      st_q.zrun <= brsi_pkg::RST_ZRUN;
    end else begin
      st_q <= st_d;
    end
  end

  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = {24'h00_0000, st_q.rdata};
  assign rx_e1_select = st_q.mode;
  // Combinational from latches so a clear drops the request at once
  assign irq_out = sum1 | sum3;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_once;
    s_req |=> s_ack_pulse;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single pulse");

  property p_los_rise;
    (live_los && !$past(live_los)) |=> st_q.sr1[brsi_pkg::ALM_LOS];
  endproperty
  a_los_rise: assert property (p_los_rise)
    else $error("signal-loss latch missed rise");

  property p_oof_rise;
    $rose(live_oof) |=> st_q.sr1[brsi_pkg::ALM_OOF];
  endproperty
  a_oof_rise: assert property (p_oof_rise)
    else $error("out-of-frame latch missed rise");

  property p_clear_event;
    $fell(live_los) |=> st_q.sr1[brsi_pkg::ALM_CLR_BASE+brsi_pkg::ALM_LOS];
  endproperty
  a_clear_event: assert property (p_clear_event)
    else $error("clear-event latch missed fall");

  property p_w1c;
    (wr_en && idx == brsi_pkg::IDX_ALARM && wbyte[brsi_pkg::ALM_LOS]
     && !(live_los && !st_q.live_prev[brsi_pkg::ALM_LOS]))
      |=> !st_q.sr1[brsi_pkg::ALM_LOS];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one did not clear latch");

  property p_irq_mask;
    ((st_q.sr1 & st_q.ier1) == 8'h00 &&
     (st_q.sr3[3:0] & st_q.ier3) == 4'h0) |-> !irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt without enabled latch");

  property p_irq_on;
    ((st_q.sr1 & st_q.ier1) != 8'h00) |-> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled latch without interrupt");

  property p_e1_zero;
    !st_q.mode |=> st_q.sr3 == 8'h00;
  endproperty
  a_e1_zero: assert property (p_e1_zero)
    else $error("E1 latch set outside E1 mode");

  property p_sixteen;
    (st_q.zrun == brsi_pkg::ZERO_RUN_LONG &&
     $past(st_q.zrun) != brsi_pkg::ZERO_RUN_LONG && !$past(st_q.mode))
      |-> st_q.sr2[brsi_pkg::DS1_Z16] && st_q.sr2[brsi_pkg::DS1_PDV];
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("sixteen-zero latch missed");

  property p_crc_fresh;
    $rose(st_q.sr3[brsi_pkg::E1_CRC_RESYNC]) |->
      $past(crc4_resync_hit && !st_q.crit_prev[2]);
  endproperty
  a_crc_fresh: assert property (p_crc_fresh)
    else $error("CRC-4 resync latch set without fresh hit");

  property p_ier3_ds1;
    (wr_en && idx == brsi_pkg::IDX_IER3 && !st_q.mode) |=> $stable(st_q.ier3);
  endproperty
  a_ier3_ds1: assert property (p_ier3_ds1)
    else $error("third enable written in DS1 mode");

  property p_pdv_window;
    (density_window_fail && ds1) |=> st_q.sr2[brsi_pkg::DS1_PDV];
  endproperty
  a_pdv_window: assert property (p_pdv_window)
    else $error("density latch missed window failure");

  property p_align_change;
    (alignment_changed && ds1) |=>
      st_q.sr2[brsi_pkg::DS1_ALIGN_CHANGE];
  endproperty
  a_align_change: assert property (p_align_change)
    else $error("alignment-change latch missed");

  property p_eight_zero;
    (z8_hit && ds1) |=> st_q.sr2[brsi_pkg::DS1_Z8];
  endproperty
  a_eight_zero: assert property (p_eight_zero)
    else $error("eight-zero latch missed");

  property p_severe;
    (severe_framing_error && ds1) |=>
      st_q.sr2[brsi_pkg::DS1_SEVERE_FRAMING];
  endproperty
  a_severe: assert property (p_severe)
    else $error("severe framing latch missed");

  property p_codeword;
    (b8zs_codeword && ds1) |=> st_q.sr2[brsi_pkg::DS1_B8ZS];
  endproperty
  a_codeword: assert property (p_codeword)
    else $error("codeword latch missed");

  property p_frame_bit;
    (frame_bit_error && ds1) |=>
      st_q.sr2[brsi_pkg::DS1_FRAME_BIT_ERR];
  endproperty
  a_frame_bit: assert property (p_frame_bit)
    else $error("frame bit error latch missed");

  property p_sig_ones;
    (sig_all_ones && st_q.mode) |=> st_q.sr3[brsi_pkg::E1_SA1];
  endproperty
  a_sig_ones: assert property (p_sig_ones)
    else $error("all-ones signalling latch missed");

  property p_sig_zeros;
    (sig_all_zeros && st_q.mode) |=> st_q.sr3[brsi_pkg::E1_SA0];
  endproperty
  a_sig_zeros: assert property (p_sig_zeros)
    else $error("all-zeros signalling latch missed");

  property p_mf_tick;
    (crc4_multiframe_tick && st_q.mode) |=>
      st_q.sr3[brsi_pkg::E1_MF_TICK];
  endproperty
  a_mf_tick: assert property (p_mf_tick)
    else $error("multiframe latch missed");

  property p_align_tick;
    (align_frame_tick && st_q.mode) |=>
      st_q.sr3[brsi_pkg::E1_ALIGN_TICK];
  endproperty
  a_align_tick: assert property (p_align_tick)
    else $error("align-frame latch missed");

endmodule : brsi_top

// >>> test/brsi_top_tb.sv
// Self-checking bench for the receive status latches and interrupt masks
`timescale 1ns/1ps
module brsi_top_tb;
  logic clk_sys, sys_rst, cyc, stb, we, ack, rxb, rxv, e1sel, irq;
  logic [9:0] adr;
  logic [3:0] sel, live, e1p;
  logic [31:0] wdat, rdat;
  logic [4:0] ds1p;
  logic [2:0] rsh;
  logic [7:0] ier1, alm, nv, msk, rd;
  logic [3:0] ier3;
  int failures, compares, seed;
  int ds1b[5] = '{0, 1, 2, 5, 7};
  logic [7:0] regs[7] = '{8'h30, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3c};

  brsi_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .live_rai(live[3]),
    .live_ais(live[2]), .live_los(live[1]), .live_oof(live[0]),
    .rx_bit(rxb), .rx_bit_valid(rxv), .density_window_fail(ds1p[4]),
    .alignment_changed(ds1p[3]), .severe_framing_error(ds1p[2]),
    .b8zs_codeword(ds1p[1]), .frame_bit_error(ds1p[0]),
    .crc4_resync_hit(rsh[2]), .cas_resync_hit(rsh[1]),
    .fas_resync_hit(rsh[0]), .sig_all_ones(e1p[3]), .sig_all_zeros(e1p[2]),
    .crc4_multiframe_tick(e1p[1]), .align_frame_tick(e1p[0]),
    .rx_e1_select(e1sel), .irq_out(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Rises land in the low nibble, falls in the high nibble
  function automatic logic [7:0] edge_latch(input logic [3:0] o, n);
    return {o & ~n, n & ~o};
  endfunction : edge_latch

  task automatic print_verdict;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= 4'h1;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      print_verdict();
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check({24'h00_0000, exp}, {rdat[31:8], rd});
  endtask : rd_chk

  // Valid zeros, one per cycle; a short run keeps its count across idle
  task automatic zeros(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      rxb <= 1'b0;
      rxv <= 1'b1;
    end
    @(posedge clk_sys);
    rxv <= 1'b0;
  endtask : zeros

  initial begin
    seed = 32'he835;
    {cyc, stb, we, rxb, rxv, adr, sel, wdat, live, e1p, ds1p, rsh} = '0;
    failures = 0;
    compares = 0;
    alm = 8'h00;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(regs[i], 8'h00);
    check(32'h0000_0000, {31'h0, irq});
    $display("reset values done");
    for (int k = 0; k < 8; k++) begin
      ier1 = 8'($random(seed));
      wb(1'b1, brsi_pkg::IDX_IER1, ier1);
      rd_chk(brsi_pkg::IDX_IER1, ier1);
      nv = 8'($random(seed));
      @(posedge clk_sys);
      live <= nv[3:0];
      alm = alm | edge_latch(live, nv[3:0]);
      @(posedge clk_sys);
      #1;
      check({31'h0, |(alm & ier1)}, {31'h0, irq});
      rd_chk(brsi_pkg::IDX_ALARM, alm);
      rd_chk(brsi_pkg::IDX_LIVE, {4'h0, nv[3:0]});
      rd_chk(brsi_pkg::IDX_SUMMARY, {7'h00, |(alm & ier1)});
      msk = 8'($random(seed));
      wb(1'b1, brsi_pkg::IDX_ALARM, msk);
      alm = alm & ~msk;
      rd_chk(brsi_pkg::IDX_ALARM, alm);
    end
    wb(1'b1, brsi_pkg::IDX_ALARM, 8'hff);
    alm = 8'h00;
    $display("alarm latches done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      ds1p <= 5'h01 << i;
      @(posedge clk_sys);
      ds1p <= 5'h00;
      wb(1'b1, brsi_pkg::IDX_DS1SR, ~(8'h01 << ds1b[i]));
      rd_chk(brsi_pkg::IDX_DS1SR, 8'h01 << ds1b[i]);
      check(32'h0000_0000, {31'h0, irq});
      wb(1'b1, brsi_pkg::IDX_DS1SR, 8'h01 << ds1b[i]);
      rd_chk(brsi_pkg::IDX_DS1SR, 8'h00);
    end
    zeros(7);
    rd_chk(brsi_pkg::IDX_DS1SR, 8'h00);
    zeros(1);
    rd_chk(brsi_pkg::IDX_DS1SR, 8'h10);
    zeros(8);
    rd_chk(brsi_pkg::IDX_DS1SR, 8'h98);
    check(32'h0000_0000, {31'h0, irq});
    @(posedge clk_sys);
    rxb <= 1'b1;
    rxv <= 1'b1;
    @(posedge clk_sys);
    rxv <= 1'b0;
    wb(1'b1, brsi_pkg::IDX_DS1SR, 8'hff);
    rd_chk(brsi_pkg::IDX_DS1SR, 8'h00);
    @(posedge clk_sys);
    e1p <= 4'hf;
    rsh <= 3'h7;
    @(posedge clk_sys);
    e1p <= 4'h0;
    rd_chk(brsi_pkg::IDX_E1SR, 8'h00);
    rsh <= 3'h0;
    wb(1'b1, brsi_pkg::IDX_IER3, 8'h0f);
    rd_chk(brsi_pkg::IDX_IER3, 8'h00);
    $display("DS1 events done");
    wb(1'b1, brsi_pkg::IDX_MODE, 8'h01);
    #1;
    check(32'h0000_0001, {31'h0, e1sel});
    rd_chk(brsi_pkg::IDX_MODE, 8'h01);
    ier3 = 4'($random(seed)) | 4'h1;
    wb(1'b1, brsi_pkg::IDX_IER3, {4'h0, ier3});
    rd_chk(brsi_pkg::IDX_IER3, {4'h0, ier3});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      e1p <= 4'h1 << i;
      @(posedge clk_sys);
      e1p <= 4'h0;
      #1;
      check({31'h0, |(ier3 & ((4'h2 << i) - 4'h1))}, {31'h0, irq});
    end
    rd_chk(brsi_pkg::IDX_E1SR, 8'h0f);
    rd_chk(brsi_pkg::IDX_SUMMARY, 8'h02);
    wb(1'b1, brsi_pkg::IDX_E1SR, 8'h0f);
    @(posedge clk_sys);
    rsh <= 3'h7;
    rd_chk(brsi_pkg::IDX_E1SR, 8'h70);
    check(32'h0000_0000, {31'h0, irq});
    wb(1'b1, brsi_pkg::IDX_E1SR, 8'h70);
    rd_chk(brsi_pkg::IDX_E1SR, 8'h00);
    @(posedge clk_sys);
    rsh <= 3'h0;
    @(posedge clk_sys);
    rsh <= 3'h7;
    rd_chk(brsi_pkg::IDX_E1SR, 8'h70);
    wb(1'b1, brsi_pkg::IDX_MODE, 8'h00);
    rd_chk(brsi_pkg::IDX_E1SR, 8'h00);
    $display("E1 events done");
    print_verdict();
  end
endmodule : brsi_top_tb
